// ===== design/pgi_pkg.sv
// Package for the private group port isolation block: sizes, defaults, carriers
package pgi_pkg;
	localparam int NPORT = 12;
	localparam int PW = 4;
	localparam int VW = 12;
	localparam int NVLAN = 16;
	localparam int VIW = 4;
	localparam logic [PW-1:0] DEF_GROUP = 4'h1;
	localparam logic [VW-1:0] DEF_VLAN = 12'h001;
	localparam logic [NPORT-1:0] ALL_PORTS = 12'hfff;
	localparam logic [NPORT-1:0] NO_PORTS = 12'h000;

	typedef logic [NPORT-1:0] pgi_mask_t;

	// Staged configuration command from management software
	typedef struct packed {
		logic valid;
		logic [2:0] op;
		logic [PW-1:0] group;
		pgi_mask_t members;
	} pgi_cmd_t;

	localparam logic [2:0] OP_ADD = 3'h1;
	localparam logic [2:0] OP_SET = 3'h2;
	localparam logic [2:0] OP_DEL = 3'h3;
	localparam logic [2:0] OP_COMMIT = 3'h4;

	// Forwarding lookup request
	typedef struct packed {
		logic valid;
		logic [PW-1:0] port;
		logic [VIW-1:0] vlan_idx;
	} pgi_req_t;

	// Forwarding answer
	typedef struct packed {
		logic valid;
		pgi_mask_t egress;
	} pgi_ans_t;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b01,
		ST_COMMIT = 2'b10
	} pgi_state_t;
endpackage

// ===== design/pgi_isolation.sv
// Private group and port isolation egress mask decision logic
module pgi_isolation
	import pgi_pkg::*;
(
	input wire logic clk,
	input wire logic nrst,
	input wire pgi_cmd_t cmd,
	input wire pgi_mask_t iso_en,
	input wire logic [NVLAN-1:0][NPORT-1:0] vlan_members,
	input wire pgi_req_t req,
	output pgi_ans_t ans,
	output logic cmd_reject,
	output logic [NPORT:1] group_active,
	output pgi_mask_t iso_state
);
	// Live and staged group tables, index 1..NPORT
	pgi_mask_t live_reg [1:NPORT];
	pgi_mask_t stage_reg [1:NPORT];

	// Group present flags, live and staged
	logic [NPORT:1] live_on_reg;
	logic [NPORT:1] stage_on_reg;

	// Isolation bits, answer and reject flag
	pgi_mask_t iso_reg;
	pgi_ans_t ans_reg;
	logic reject_reg;

	// Commit sequencer
	pgi_state_t state_reg;
	pgi_state_t state_next;

	// Group number must be within switch port range
	function automatic logic grp_ok(input logic [PW-1:0] g);
		grp_ok = (g != '0) && (32'(g) <= NPORT);
	endfunction

	// Ingress port number must name a real port
	function automatic logic port_ok(input logic [PW-1:0] p);
		port_ok = 32'(p) < NPORT;
	endfunction

	// Reset member mask of one group row: group 1 holds every port
	function automatic pgi_mask_t def_members(input int g);
		def_members = (g == int'(DEF_GROUP)) ? ALL_PORTS : NO_PORTS;
	endfunction

	// Reset present flag of one group row: only group 1 exists
	function automatic logic def_on(input int g);
		def_on = (g == int'(DEF_GROUP));
	endfunction

	// Command screening: group number must be in range
	wire logic cmd_ok = grp_ok(cmd.group);
	wire logic is_commit = cmd.valid && cmd.op == OP_COMMIT;
	// Commit ignores the group field and is never rejected
	wire logic bad_cmd = cmd.valid && !is_commit && !cmd_ok;

	// Staging edits, taken only for a group number in range
	wire logic is_add = cmd.valid && cmd_ok && cmd.op == OP_ADD;
	wire logic is_set = cmd.valid && cmd_ok && cmd.op == OP_SET;
	wire logic is_del = cmd.valid && cmd_ok && cmd.op == OP_DEL;
	// A set on a group not staged as present is dropped
	wire logic set_ok = is_set && stage_on_reg[cmd.group];
	// Add and delete both empty the staged row
	wire logic clr_row = is_add || is_del;

	// Union of live groups the ingress port belongs to, independent of VLAN
	pgi_mask_t grp_union;
	always_comb
	begin
		grp_union = NO_PORTS;
		for (int g = 1; g <= NPORT; g++)
			if (live_on_reg[g] && live_reg[g][req.port])
				grp_union = grp_union | live_reg[g];
	end

	// VLAN side of the decision
	wire pgi_mask_t vmask = vlan_members[req.vlan_idx];
	wire logic src_in_vlan = vmask[req.port];

	// Group side and ingress attributes
	// Ports past the last one never forward
	wire logic src_ok = port_ok(req.port);
	wire logic src_in_grp = |grp_union;
	wire logic src_iso = iso_reg[req.port];
	wire pgi_mask_t self_bit = pgi_mask_t'(1) << req.port;

	// Isolated ingress reaches only promiscuous group members
	wire pgi_mask_t iso_lim = grp_union & ~iso_reg;
	wire pgi_mask_t base = src_iso ? (vmask & iso_lim) : vmask;
	wire logic fwd_ok = src_ok && src_in_vlan && src_in_grp;
	wire pgi_mask_t egress_next = fwd_ok ?
		(base & ~self_bit) : NO_PORTS;

	// Answer carries a mask only while a request is present
	wire pgi_mask_t ans_mask = req.valid ? egress_next : NO_PORTS;
	// Struct that the answer register loads
	wire pgi_ans_t ans_next = {req.valid, ans_mask};

	// Live table copies the staged rows on this cycle
	wire logic do_commit = (state_reg == ST_COMMIT);

	// Commit sequencing state
	always_comb
	begin
		case (state_reg)
			ST_IDLE: state_next = is_commit ? ST_COMMIT : ST_IDLE;
			ST_COMMIT: state_next = ST_IDLE;
			default: state_next = ST_IDLE;
		endcase
	end

	// Answer register: one decision per request, one cycle later
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
			ans_reg <= '0;
		else
			ans_reg <= ans_next;
	end

	// Reject flag pulses for one cycle after a bad group number
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
			reject_reg <= 1'b0;
		else
			reject_reg <= bad_cmd;
	end

	// Commit sequencer register
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
			state_reg <= ST_IDLE;
		else
			state_reg <= state_next;
	end

	// Isolation bits: one per port, shared by every group
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
			iso_reg <= NO_PORTS;
		else
			iso_reg <= iso_en;
	end

	// Staged group present flags: add sets, delete clears
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			for (int g = 1; g <= NPORT; g++)
				stage_on_reg[g] <= def_on(g);
		end
		else if (clr_row)
			stage_on_reg[cmd.group] <= is_add;
	end

	// Staged member masks: add and delete empty a row, set fills it
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			for (int g = 1; g <= NPORT; g++)
				stage_reg[g] <= def_members(g);
		end
		else if (clr_row)
			stage_reg[cmd.group] <= NO_PORTS;
		else if (set_ok)
			stage_reg[cmd.group] <= cmd.members;
	end

	// Live member masks take the staged copy one cycle after commit
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			for (int g = 1; g <= NPORT; g++)
				live_reg[g] <= def_members(g);
		end
		else if (do_commit)
		begin
			for (int g = 1; g <= NPORT; g++)
				live_reg[g] <= stage_reg[g];
		end
	end

	// Live group present flags switch at the same edge
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			for (int g = 1; g <= NPORT; g++)
				live_on_reg[g] <= def_on(g);
		end
		else if (do_commit)
			live_on_reg <= stage_on_reg;
	end

	// Outputs straight from flip-flops
	assign ans = ans_reg;
	assign cmd_reject = reject_reg;
	assign group_active = live_on_reg;
	assign iso_state = iso_reg;
endmodule

// ===== bench/pgi_vtab.sv
// VLAN table model feeding membership masks
module pgi_vtab
	import pgi_pkg::*;
(
	input wire logic clk,
	input wire logic nrst,
	output logic [NVLAN-1:0][NPORT-1:0] vlan_members
);
	timeunit 1ns;
	timeprecision 1ps;
	// VLAN 1 holds all ports, VLAN 2 ports 0 to 3
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
			vlan_members <= {{13{12'h000}}, 12'h00f, ALL_PORTS, 12'h000};
	end
endmodule

// ===== bench/pgi_isolation_properties.sv
// Port checks of the isolation block: answer latency, forwarding rules, isolation register, reject flag
module pgi_isolation_properties
	import pgi_pkg::*;
(
	input wire logic clk,
	input wire logic nrst,
	input wire pgi_cmd_t cmd,
	input wire pgi_mask_t iso_en,
	input wire logic [NVLAN-1:0][NPORT-1:0] vlan_members,
	input wire pgi_req_t req,
	input wire pgi_ans_t ans,
	input wire logic cmd_reject,
	input wire pgi_mask_t iso_state
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);
	// Command with a group number outside 1 to 12
	wire bad = cmd.valid && cmd.op != OP_COMMIT
		&& (cmd.group == 4'h0 || cmd.group > 4'hc);
	ans_lat_a: assert property (req.valid |=> ans.valid) else $error("lat");
	ans_idle_a: assert property (!req.valid |=> !ans.valid && ans.egress == 0)
		else $error("idle");
	self_out_a: assert property (req.valid |=> !ans.egress[$past(req.port)])
		else $error("self");
	vlan_gate_a: assert property (req.valid |=>
		(ans.egress & ~$past(vlan_members[req.vlan_idx])) == 0) else $error("vl");
	iso_pair_a: assert property (req.valid && iso_state[req.port] |=>
		(ans.egress & $past(iso_state)) == 0) else $error("iso");
	iso_reg_a: assert property ($past(nrst) |-> iso_state == $past(iso_en))
		else $error("isr");
	bad_grp_a: assert property (bad |=> cmd_reject) else $error("rej");
	good_grp_a: assert property (!bad |=> !cmd_reject) else $error("nrj");
	cover property (cmd_reject);
	cover property (ans.valid && ans.egress != 0);
	cover property (req.valid && iso_state[req.port]);
endmodule
bind pgi_isolation pgi_isolation_properties pgi_isolation_properties_i(
	.clk(clk), .nrst(nrst), .cmd(cmd), .iso_en(iso_en), .req(req), .ans(ans),
	.vlan_members(vlan_members), .cmd_reject(cmd_reject), .iso_state(iso_state));

// ===== bench/pgi_isolation_tb_top.sv
// Self-checking bench of the isolation block
module pgi_isolation_tb_top
	import pgi_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 0;
	logic nrst = 0;
	pgi_cmd_t cmd = '0;
	pgi_mask_t iso_en = '0;
	pgi_req_t req = '0;
	logic [NVLAN-1:0][NPORT-1:0] vm;
	pgi_ans_t ans;
	logic rej;
	logic [NPORT:1] ga;
	pgi_mask_t iso;
	int bad_count = 0;
	int checks_done = 0;
	always #5 clk = ~clk;
	pgi_vtab pgi_vtab_i(.clk(clk), .nrst(nrst), .vlan_members(vm));
	pgi_isolation pgi_isolation_i(.clk(clk), .nrst(nrst), .cmd(cmd),
		.iso_en(iso_en), .vlan_members(vm), .req(req), .ans(ans),
		.cmd_reject(rej), .group_active(ga), .iso_state(iso));
	task end_sim;
		$display("bad %0d of %0d", bad_count, checks_done);
		if (bad_count == 0 && checks_done > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task chk(input logic [11:0] got, input logic [11:0] exp);
		checks_done++;
		if (got !== exp)
		begin
			bad_count++;
			$display("wrong value at %0t: %h not %h", $time, got, exp);
		end
	endtask
	// One command, then its reject flag
	task cmd_op(input logic [2:0] o, input logic [3:0] g, input logic r);
		@(negedge clk) cmd = '{1'b1, o, g, 12'h0f0};
		@(negedge clk) cmd.valid = 1'b0;
		chk({11'h0, rej}, {11'h0, r});
	endtask
	// One lookup, then its egress mask
	task look(input logic [3:0] p, input logic [3:0] v, input logic [11:0] e);
		@(negedge clk) req = '{1'b1, p, v};
		@(negedge clk) req.valid = 1'b0;
		chk(ans.egress, e);
	endtask
	initial
	begin
		#100000;
		bad_count++;
		end_sim;
	end
	initial
	begin
		repeat (6) @(negedge clk);
		nrst = 1;
		look(4'h0, 4'h1, 12'hffe);
		chk(ga, 12'h001);
		chk(iso, 12'h000);
		look(4'h5, 4'h2, 12'h000);
		cmd_op(OP_ADD, 4'h0, 1);
		cmd_op(OP_ADD, 4'hd, 1);
		cmd_op(OP_ADD, 4'h3, 0);
		cmd_op(OP_SET, 4'h3, 0);
		cmd_op(OP_DEL, 4'h1, 0);
		cmd_op(OP_ADD, 4'h5, 0);
		look(4'h0, 4'h1, 12'hffe);
		cmd_op(OP_COMMIT, 4'h0, 0);
		repeat (2) @(negedge clk);
		chk(ga, 12'h014);
		look(4'h0, 4'h1, 12'h000);
		look(4'h4, 4'h1, 12'hfef);
		$display("group test done");
		iso_en = 12'h030;
		@(negedge clk);
		chk(iso, 12'h030);
		look(4'h4, 4'h1, 12'h0c0);
		look(4'h7, 4'h1, 12'hf7f);
		$display("isolation test done");
		end_sim;
	end
endmodule
